// *** rtl/dc_time_counter.sv ***
// local nanosecond time counter, advanced every clock and loadable by the master
`include "slave_cfg.svh"
module dc_time_counter
    import slave_pkg::*;
(
    input wire logic    clock,
    input wire logic    resetn,
    dc_time_if.counter  tbus
);
    logic [63:0] time_reg;
    logic [63:0] time_next;

    // the master owns alignment; between loads the counter free-runs at the clock rate
    always_comb begin
        time_next = time_reg + 64'(`TIME_STEP);
        if (tbus.load) begin
            time_next = tbus.load_value;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            time_reg <= `TIME_RESET_VALUE;
        end else begin
            time_reg <= time_next;
        end
    end

    assign tbus.now = time_reg;

    a_time_advance: assert property (@(posedge clock) disable iff (!resetn)
        // the edge that releases reset still holds the counter at zero
        $past(resetn) && !$past(tbus.load) |->
        time_reg == $past(time_reg) + 64'(`TIME_STEP))
        else $error("time counter did not advance by one clock period");
    a_time_load: assert property (@(posedge clock) disable iff (!resetn)
        tbus.load |=> time_reg == $past(tbus.load_value))
        else $error("time counter did not take the loaded value");

endmodule // dc_time_counter

// *** rtl/dc_time_if.sv ***
// carrier between the controller and the local time counter
interface dc_time_if;
    logic        load;
    logic [63:0] load_value;
    logic [63:0] now;

    modport counter (input load, input load_value, output now);
    modport user    (output load, output load_value, input now);
endinterface

// *** rtl/slave_cfg.svh ***
// constants for the slave state controller and its local time counter
// How it works
// - after reset sit in init with mailbox and process data both blocked
// - init to preoperational only when the mailbox channels report a good setup
// - preoperational accepts mailbox traffic but no process data
// - preoperational to safe operational needs good process-data settings and, when time is used, good time settings
// - current inputs are written to the input memory before safe operational is taken
// - safe operational allows all traffic, refreshes inputs, holds outputs safe while the watchdog is enabled
// - watchdog forces safe outputs in safe operational only; with it disabled outputs follow there too
// - operational drives outputs from master data and allows all traffic
// - boot is entered only from init; other requests are refused
// - boot accepts only file-transfer mailbox traffic, nothing else
// - 64-bit local time counter in nanoseconds, zero at start of year 2000
// - low 32 bits are also offered; they wrap after about 4.2 seconds
`ifndef SLAVE_CFG_SVH
`define SLAVE_CFG_SVH

`define CODE_INIT          4'h1
`define CODE_PREOPERATIONAL 4'h2
`define CODE_BOOT          4'h3
`define CODE_SAFE          4'h4
`define CODE_OPERATIONAL   4'h8

`define MBX_PROTO_FILE     4'h4
`define SAFE_OUTPUT_VALUE  8'h00
`define IO_WIDTH           8

`define CLOCK_PERIOD_NS    100
`define TIME_UNIT_NS       1
`define TIME_STEP          (`CLOCK_PERIOD_NS / `TIME_UNIT_NS)
`define TIME_RESET_VALUE   64'h0000_0000_0000_0000

`endif

// *** rtl/slave_pkg.sv ***
// types shared by the slave state controller modules
package slave_pkg;
`include "slave_cfg.svh"

    typedef enum logic [3:0] {
        init_state             = `CODE_INIT,
        preoperational_state   = `CODE_PREOPERATIONAL,
        boot_state             = `CODE_BOOT,
        safe_operational_state = `CODE_SAFE,
        operational_state      = `CODE_OPERATIONAL
    } slave_state_t;

    typedef enum logic [1:0] {
        phase_settled = 2'b00,
        phase_capture = 2'b01
    } entry_phase_t;

endpackage

// *** rtl/slave_state_machine_dc.sv ***
// slave state controller: state transitions, traffic gating, output and input handling
`include "slave_cfg.svh"
module slave_state_machine_dc
    import slave_pkg::*;
(
    input  wire logic                   clock,
    input  wire logic                   resetn,
    input  wire logic                   request_valid,
    input  wire logic [3:0]             requested_state,
    input  wire logic                   mailbox_config_ok,
    input  wire logic                   pd_config_ok,
    input  wire logic                   dc_used,
    input  wire logic                   dc_config_ok,
    input  wire logic                   watchdog_enable,
    input  wire logic                   error_ack,
    input  wire logic                   mailbox_request,
    input  wire logic [3:0]             mailbox_protocol,
    input  wire logic                   pd_request,
    input  wire logic [`IO_WIDTH-1:0]   master_outputs,
    input  wire logic [`IO_WIDTH-1:0]   input_pins,
    input  wire logic                   time_load,
    input  wire logic [63:0]            time_load_value,
    output logic [3:0]                  current_state,
    output logic                        capture_pending,
    output logic                        transition_error,
    output logic                        mailbox_allowed,
    output logic                        process_data_allowed,
    output logic                        mailbox_accept,
    output logic                        mailbox_reject,
    output logic                        pd_accept,
    output logic [`IO_WIDTH-1:0]        physical_outputs,
    output logic [`IO_WIDTH-1:0]        input_image,
    output logic                        input_write,
    output logic [63:0]                 time_now,
    output logic [31:0]                 time_now_low
);
    slave_state_t           state_reg;
    slave_state_t           state_next;
    entry_phase_t           phase_reg;
    entry_phase_t           phase_next;
    logic                   error_reg;
    logic                   error_next;
    logic                   fail;
    logic [`IO_WIDTH-1:0]   pins_meta_reg;
    logic [`IO_WIDTH-1:0]   pins_sync_reg;
    logic [`IO_WIDTH-1:0]   outputs_reg;
    logic [`IO_WIDTH-1:0]   outputs_next;
    logic [`IO_WIDTH-1:0]   image_reg;
    logic                   write_reg;
    logic                   write_next;
    logic                   drive_next;

    dc_time_if tbus ();

    dc_time_counter u_time (
        .clock  (clock),
        .resetn (resetn),
        .tbus   (tbus.counter)
    );

    assign tbus.load       = time_load;
    assign tbus.load_value = time_load_value;
    assign time_now        = tbus.now;
    // readers of the short view must allow for its wrap
    assign time_now_low    = tbus.now[31:0];

    // pins come from outside the clock domain
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            pins_meta_reg <= '0;
            pins_sync_reg <= '0;
        end else begin
            pins_meta_reg <= input_pins;
            pins_sync_reg <= pins_meta_reg;
        end
    end

    // transition control; requests arriving during the capture cycle are ignored
    always_comb begin
        state_next = state_reg;
        phase_next = phase_settled;
        fail       = 1'b0;
        if (phase_reg == phase_capture) begin
            state_next = safe_operational_state;
        end else if (request_valid && requested_state != state_reg) begin
            case (requested_state)
                `CODE_INIT: begin
                    state_next = init_state;
                end
                `CODE_PREOPERATIONAL: begin
                    if ((state_reg == init_state && mailbox_config_ok) ||
                        state_reg == safe_operational_state ||
                        state_reg == operational_state) begin
                        state_next = preoperational_state;
                    end else begin
                        fail = 1'b1;
                    end
                end
                `CODE_SAFE: begin
                    if (state_reg == preoperational_state && pd_config_ok &&
                        (!dc_used || dc_config_ok)) begin
                        phase_next = phase_capture;
                    end else if (state_reg == operational_state) begin
                        state_next = safe_operational_state;
                    end else begin
                        fail = 1'b1;
                    end
                end
                `CODE_OPERATIONAL: begin
                    // output data validity is the master's duty before this request
                    if (state_reg == safe_operational_state) begin
                        state_next = operational_state;
                    end else begin
                        fail = 1'b1;
                    end
                end
                `CODE_BOOT: begin
                    if (state_reg == init_state) begin
                        state_next = boot_state;
                    end else begin
                        fail = 1'b1;
                    end
                end
                default: begin
                    fail = 1'b1;
                end
            endcase
        end
        // a new failure wins over an acknowledge in the same cycle
        error_next = error_reg;
        if (fail) begin
            error_next = 1'b1;
        end else if (error_ack) begin
            error_next = 1'b0;
        end
    end

    // output and input image handling follows the state being entered
    always_comb begin
        drive_next = (state_next == operational_state) ||
                     (state_next == safe_operational_state && !watchdog_enable);
        outputs_next = drive_next ? master_outputs : `SAFE_OUTPUT_VALUE;
        write_next = (phase_next == phase_capture) ||
                     state_next == safe_operational_state ||
                     state_next == operational_state;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_reg   <= init_state;
            phase_reg   <= phase_settled;
            error_reg   <= 1'b0;
            outputs_reg <= `SAFE_OUTPUT_VALUE;
            image_reg   <= '0;
            write_reg   <= 1'b0;
        end else begin
            state_reg   <= state_next;
            phase_reg   <= phase_next;
            error_reg   <= error_next;
            outputs_reg <= outputs_next;
            image_reg   <= pins_sync_reg;
            write_reg   <= write_next;
        end
    end

    // traffic gating, answered in the same cycle as the request
    always_comb begin
        mailbox_allowed = state_reg == preoperational_state ||
                          state_reg == safe_operational_state ||
                          state_reg == operational_state;
        process_data_allowed = state_reg == safe_operational_state ||
                               state_reg == operational_state;
        mailbox_accept = mailbox_request && (mailbox_allowed ||
                         (state_reg == boot_state && mailbox_protocol == `MBX_PROTO_FILE));
        mailbox_reject = mailbox_request && !mailbox_accept;
        pd_accept      = pd_request && process_data_allowed;
    end

    assign current_state    = state_reg;
    assign capture_pending  = (phase_reg == phase_capture);
    assign transition_error = error_reg;
    assign physical_outputs = outputs_reg;
    assign input_image      = image_reg;
    assign input_write      = write_reg;

    a_init_blocked: assert property (@(posedge clock) disable iff (!resetn)
        state_reg == init_state |-> !mailbox_allowed && !process_data_allowed)
        else $error("traffic allowed in init");
    a_mailbox_check: assert property (@(posedge clock) disable iff (!resetn)
        request_valid && requested_state == `CODE_PREOPERATIONAL && state_reg == init_state &&
        phase_reg == phase_settled && !mailbox_config_ok |=> state_reg == init_state && error_reg)
        else $error("preoperational taken with bad mailbox setup");
    a_preop_gating: assert property (@(posedge clock) disable iff (!resetn)
        state_reg == preoperational_state |-> mailbox_allowed && !process_data_allowed)
        else $error("wrong gating in preoperational");
    a_safe_entry_checked: assert property (@(posedge clock) disable iff (!resetn)
        state_reg == safe_operational_state && $past(state_reg) == preoperational_state |->
        $past(pd_config_ok, 2) && (!$past(dc_used, 2) || $past(dc_config_ok, 2)))
        else $error("safe operational taken with bad settings");
    a_capture_first: assert property (@(posedge clock) disable iff (!resetn)
        phase_reg == phase_capture |-> input_write && state_reg == preoperational_state
        ##1 state_reg == safe_operational_state)
        else $error("inputs not written before safe operational entry");
    a_safe_hold: assert property (@(posedge clock) disable iff (!resetn)
        state_reg == safe_operational_state && $past(watchdog_enable) |->
        physical_outputs == `SAFE_OUTPUT_VALUE)
        else $error("outputs not safe under watchdog");
    a_input_refresh: assert property (@(posedge clock) disable iff (!resetn)
        process_data_allowed |-> input_write && input_image == $past(pins_sync_reg))
        else $error("inputs not refreshed");
    a_run_follow: assert property (@(posedge clock) disable iff (!resetn)
        state_reg == operational_state |-> physical_outputs == $past(master_outputs))
        else $error("outputs do not follow master data");
    a_boot_entry: assert property (@(posedge clock) disable iff (!resetn)
        state_reg == boot_state && $past(state_reg) != boot_state |->
        $past(state_reg) == init_state)
        else $error("boot entered from a state other than init");
    a_boot_file_only: assert property (@(posedge clock) disable iff (!resetn)
        state_reg == boot_state && mailbox_request |->
        mailbox_accept == (mailbox_protocol == `MBX_PROTO_FILE) && !pd_accept)
        else $error("wrong mailbox gating in boot");
    a_refusal_holds: assert property (@(posedge clock) disable iff (!resetn)
        fail |=> state_reg == $past(state_reg) && error_reg)
        else $error("refused request changed state or left no error");

    c_reach_run: cover property (@(posedge clock) disable iff (!resetn)
        state_reg == operational_state);
    c_reach_boot: cover property (@(posedge clock) disable iff (!resetn)
        state_reg == boot_state);
    c_capture: cover property (@(posedge clock) disable iff (!resetn)
        phase_reg == phase_capture);
    c_refusal: cover property (@(posedge clock) disable iff (!resetn)
        fail && error_ack);

endmodule // slave_state_machine_dc

// *** verification/master_model.sv ***
// bus master model: state requests, channel setup flags, output data and time alignment
module master_model (
    input  wire logic       clock,
    input  wire logic       resetn,
    output logic            request_valid,
    output logic [3:0]      requested_state,
    output logic            mailbox_config_ok,
    output logic            pd_config_ok,
    output logic            dc_used,
    output logic            dc_config_ok,
    output logic [7:0]      master_outputs,
    output logic            time_load,
    output logic [63:0]     time_load_value
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        request_valid     = 1'b0;
        requested_state   = 4'h1;
        mailbox_config_ok = 1'b0;
        pd_config_ok      = 1'b0;
        dc_used           = 1'b0;
        dc_config_ok      = 1'b0;
        master_outputs    = 8'h00;
        time_load         = 1'b0;
        time_load_value   = 64'h0;
    end

    // one-cycle strobe, held up to the taking edge and dropped just after it
    task automatic request(input logic [3:0] code);
        while (resetn !== 1'b1) @(posedge clock);
        @(posedge clock);
        request_valid   <= 1'b1;
        requested_state <= code;
        @(posedge clock);
        request_valid   <= 1'b0;
    endtask

    // mailbox channels 0/1, process-data channels from 2 and time settings
    task automatic configure(input logic mbx, input logic pd, input logic dcu, input logic dco);
        @(posedge clock);
        mailbox_config_ok <= mbx;
        pd_config_ok      <= pd;
        dc_used           <= dcu;
        dc_config_ok      <= dco;
    endtask

    // output data is valid before operational is asked for
    task automatic send_outputs(input logic [7:0] data);
        @(posedge clock);
        master_outputs <= data;
    endtask

    // alignment modelled as a single load of the counter
    task automatic align_time(input logic [63:0] value);
        @(posedge clock);
        time_load       <= 1'b1;
        time_load_value <= value;
        @(posedge clock);
        time_load       <= 1'b0;
    endtask
endmodule // master_model

// *** verification/tb.sv ***
// self-checking bench for the slave state controller
module tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic        clock, resetn, request_valid, mailbox_config_ok, pd_config_ok;
    logic        dc_used, dc_config_ok, watchdog_enable, error_ack, mailbox_request;
    logic        pd_request, time_load, capture_pending, transition_error;
    logic        mailbox_allowed, process_data_allowed, mailbox_accept, mailbox_reject;
    logic        pd_accept, input_write;
    logic [3:0]  requested_state, mailbox_protocol, current_state;
    logic [7:0]  master_outputs, input_pins, physical_outputs, input_image;
    logic [63:0] time_load_value, time_now;
    logic [31:0] time_now_low;
    int          miscompares = 0;
    int          checked = 0;

    master_model u_master (.clock(clock), .resetn(resetn), .request_valid(request_valid),
        .requested_state(requested_state), .mailbox_config_ok(mailbox_config_ok),
        .pd_config_ok(pd_config_ok), .dc_used(dc_used), .dc_config_ok(dc_config_ok),
        .master_outputs(master_outputs), .time_load(time_load),
        .time_load_value(time_load_value));

    slave_state_machine_dc u_dut (.clock(clock), .resetn(resetn),
        .request_valid(request_valid), .requested_state(requested_state),
        .mailbox_config_ok(mailbox_config_ok), .pd_config_ok(pd_config_ok),
        .dc_used(dc_used), .dc_config_ok(dc_config_ok), .watchdog_enable(watchdog_enable),
        .error_ack(error_ack), .mailbox_request(mailbox_request),
        .mailbox_protocol(mailbox_protocol), .pd_request(pd_request),
        .master_outputs(master_outputs), .input_pins(input_pins), .time_load(time_load),
        .time_load_value(time_load_value), .current_state(current_state),
        .capture_pending(capture_pending), .transition_error(transition_error),
        .mailbox_allowed(mailbox_allowed), .process_data_allowed(process_data_allowed),
        .mailbox_accept(mailbox_accept), .mailbox_reject(mailbox_reject),
        .pd_accept(pd_accept), .physical_outputs(physical_outputs),
        .input_image(input_image), .input_write(input_write), .time_now(time_now),
        .time_now_low(time_now_low));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
        checked++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, got);
            miscompares++;
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // offers one mailbox and one process-data transfer, judged in the same cycle
    task automatic traffic(input logic [3:0] proto, input logic mbx_ok, input logic pd_ok);
        @(posedge clock);
        mailbox_request  <= 1'b1;
        mailbox_protocol <= proto;
        pd_request       <= 1'b1;
        #1;
        chk("mailbox_accept", {63'h0, mbx_ok}, {63'h0, mailbox_accept});
        chk("mailbox_reject", {63'h0, !mbx_ok}, {63'h0, mailbox_reject});
        chk("pd_accept", {63'h0, pd_ok}, {63'h0, pd_accept});
        @(posedge clock);
        mailbox_request  <= 1'b0;
        pd_request       <= 1'b0;
    endtask

    // a refused move keeps the state and leaves a sticky flag until acknowledged
    task automatic refused(input logic [3:0] code, input logic [3:0] stay);
        u_master.request(code);
        tick(1);
        chk("state kept", {60'h0, stay}, {60'h0, current_state});
        chk("error set", 64'h1, {63'h0, transition_error});
        @(posedge clock);
        error_ack <= 1'b1;
        @(posedge clock);
        error_ack <= 1'b0;
        tick(1);
        chk("error cleared", 64'h0, {63'h0, transition_error});
    endtask

    task automatic moved(input logic [3:0] code);
        u_master.request(code);
        #1;
        chk("new state", {60'h0, code}, {60'h0, current_state});
    endtask

    task automatic s_init;
        chk("allowed in init", 64'h0, {62'h0, mailbox_allowed, process_data_allowed});
        traffic(4'h2, 1'b0, 1'b0);
        refused(4'h2, 4'h1);
        refused(4'h8, 4'h1);
        // a refusal and an acknowledge on the same edge: the refusal must win
        fork
            u_master.request(4'h8);
            begin
                @(posedge clock);
                error_ack <= 1'b1;
                @(posedge clock);
                error_ack <= 1'b0;
            end
        join
        tick(1);
        chk("error kept", 64'h1, {63'h0, transition_error});
    endtask

    task automatic s_boot;
        moved(4'h3);
        traffic(4'h4, 1'b1, 1'b0);
        traffic(4'h2, 1'b0, 1'b0);
        refused(4'h2, 4'h3);
        moved(4'h1);
    endtask

    task automatic s_preop_safe;
        u_master.configure(1'b1, 1'b1, 1'b1, 1'b0);
        moved(4'h2);
        chk("allowed in preop", 64'h2, {62'h0, mailbox_allowed, process_data_allowed});
        traffic(4'h3, 1'b1, 1'b0);
        refused(4'h3, 4'h2);
        refused(4'h4, 4'h2);
        u_master.configure(1'b1, 1'b1, 1'b1, 1'b1);
        input_pins <= 8'h3c;
        tick(4);
        u_master.request(4'h4);
        #1;
        chk("snapshot strobe", 64'h3, {62'h0, capture_pending, input_write});
        chk("snapshot data", 64'h3c, {56'h0, input_image});
        chk("not yet safe", 64'h2, {60'h0, current_state});
        tick(1);
        chk("safe entered", 64'h4, {60'h0, current_state});
        chk("allowed in safe", 64'h3, {62'h0, mailbox_allowed, process_data_allowed});
        traffic(4'h3, 1'b1, 1'b1);
        input_pins <= 8'hc1;
        tick(4);
        chk("inputs refreshed", 64'hc1, {56'h0, input_image});
    endtask

    task automatic s_outputs;
        u_master.send_outputs(8'h5a);
        tick(3);
        chk("safe outputs", 64'h0, {56'h0, physical_outputs});
        @(posedge clock);
        watchdog_enable <= 1'b0;
        tick(3);
        chk("watchdog off", 64'h5a, {56'h0, physical_outputs});
        @(posedge clock);
        watchdog_enable <= 1'b1;
        tick(3);
        chk("watchdog on", 64'h0, {56'h0, physical_outputs});
        moved(4'h8);
        u_master.send_outputs(8'hc3);
        tick(3);
        chk("op outputs", 64'hc3, {56'h0, physical_outputs});
        traffic(4'h1, 1'b1, 1'b1);
        refused(4'h3, 4'h8);
    endtask

    // the way back down from operational, then a code that names no state
    task automatic s_return;
        moved(4'h4);
        moved(4'h2);
        moved(4'h1);
        chk("allowed back in init", 64'h0, {62'h0, mailbox_allowed, process_data_allowed});
        refused(4'h5, 4'h1);
    endtask

    // load just below a 32-bit wrap so both views are exercised
    task automatic s_time;
        u_master.align_time(64'h0000_0001_ffff_ffc0);
        #1;
        chk("time loaded", 64'h0000_0001_ffff_ffc0, time_now);
        tick(1);
        chk("time step", 64'h0000_0002_0000_0024, time_now);
        chk("time low wrap", 64'h24, {32'h0, time_now_low});
    endtask

    task automatic test_done;
        if (miscompares == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        resetn           = 1'b0;
        watchdog_enable  = 1'b1;
        error_ack        = 1'b0;
        mailbox_request  = 1'b0;
        mailbox_protocol = 4'h0;
        pd_request       = 1'b0;
        input_pins       = 8'ha5;
        tick(6);
        chk("reset state", 64'h1, {60'h0, current_state});
        chk("reset time", 64'h0, time_now);
        @(posedge clock);
        resetn <= 1'b1;
        tick(1);
        chk("first step", 64'h64, time_now);
        s_init();
        s_boot();
        s_preop_safe();
        s_outputs();
        s_return();
        s_time();
        test_done();
    end

    // run takes about 110 cycles; this bounds a hang
    initial begin
        #400000;
        miscompares++;
        test_done();
    end
endmodule // tb
